/* File: src/video_out_pkg.sv */
package video_out_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses, low address bits decoded)
  // ---------------------------------------------------------------
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  ADDR_CLIP       = 8'h00;
  localparam logic [7:0]  ADDR_FILL       = 8'h04;
  localparam logic [7:0]  ADDR_VERTICAL_IRQ       = 8'h08;
  localparam logic [7:0]  ADDR_CTRL       = 8'h0C;
  localparam logic [7:0]  ADDR_IMG_OFF    = 8'h10;
  localparam logic [7:0]  ADDR_IMG_SIZE   = 8'h14;
  localparam logic [7:0]  ADDR_STATUS     = 8'h18;

  // ---------------------------------------------------------------
  // Reset values and writable masks
  // ---------------------------------------------------------------
  localparam logic [31:0] CLIP_RESET      = 32'hF010EB10;
  localparam logic [31:0] FILL_RESET      = 32'h00000000;
  localparam logic [31:0] VERTICAL_IRQ_RESET      = 32'h00000000;
  localparam logic [31:0] CTRL_RESET      = 32'h00000000;
  localparam logic [31:0] IMG_OFF_RESET   = 32'h00000000;
  localparam logic [31:0] IMG_SIZE_RESET  = 32'h0FFF0FFF;
  localparam logic [31:0] VERTICAL_IRQ_MASK       = 32'h8FFF8FFF;
  localparam logic [31:0] FILL_YC_MASK    = 32'hFFFF00FF;
  localparam logic [31:0] FILL_RAW_MASK   = 32'h000FFFFF;
  localparam logic [31:0] CTRL_MASK       = 32'h0000001F;
  localparam logic [31:0] IMG_MASK        = 32'h0FFF0FFF;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CLIP_CHI_LSB   = 24;
  localparam int CLIP_CLO_LSB   = 16;
  localparam int CLIP_YHI_LSB   = 8;
  localparam int CLIP_YLO_LSB   = 0;
  localparam int FILL_CR_LSB    = 24;
  localparam int FILL_CB_LSB    = 16;
  localparam int FILL_Y_LSB     = 0;
  localparam int F2_EN_BIT      = 31;
  localparam int F2_LINE_LSB    = 16;
  localparam int F1_EN_BIT      = 15;
  localparam int F1_LINE_LSB    = 0;
  localparam int CTRL_MODE_LSB  = 0;
  localparam int CTRL_WIDTH_LSB = 2;
  localparam int CTRL_BLANKING_DISABLE    = 4;
  localparam int IMG_V_LSB      = 16;
  localparam int IMG_H_LSB      = 0;

  // ---------------------------------------------------------------
  // Modes, bus widths, sample phases, widths
  // ---------------------------------------------------------------
  localparam logic [1:0]  MODE_BT656  = 2'h0;
  localparam logic [1:0]  MODE_YC     = 2'h1;
  localparam logic [1:0]  WIDTH_8     = 2'h0;
  localparam logic [1:0]  WIDTH_10    = 2'h1;
  localparam logic [1:0]  WIDTH_16    = 2'h2;
  localparam logic [19:0] RAW_MASK_8  = 20'h000FF;
  localparam logic [19:0] RAW_MASK_10 = 20'h003FF;
  localparam logic [19:0] RAW_MASK_16 = 20'h0FFFF;
  localparam logic [19:0] RAW_MASK_20 = 20'hFFFFF;
  localparam logic [1:0]  PHASE_CB    = 2'h0;
  localparam logic [1:0]  PHASE_CR    = 2'h2;
  localparam int          LINE_W      = 12;
  localparam int          LANE_W      = 10;
  localparam int          OUT_W       = 20;
  localparam logic [1:0]  LSB_ZERO    = 2'h0;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

  // Timing from the counter logic, one sample per clock
  typedef struct packed {
    logic              active;
    logic              field2;
    logic              line_done;
    logic [LINE_W-1:0] frame_line;
    logic [LINE_W-1:0] image_line;
    logic [LINE_W-1:0] image_pixel;
    logic [1:0]        phase;
  } timing_t;

  // Head of the output FIFO
  typedef struct packed {
    logic             empty;
    logic [OUT_W-1:0] data;
  } fifo_word_t;

endpackage : video_out_pkg

/* File: src/sample_clamp.sv */
`timescale 1ns/1ps
`default_nettype none
module sample_clamp
  import video_out_pkg::*;
(
  input  wire logic [LANE_W-1:0] sample_i,
  input  wire logic [7:0]        low_i,
  input  wire logic [7:0]        high_i,
  input  wire logic              enable_i,
  output logic      [LANE_W-1:0] result_o
);

  // ---------------------------------------------------------------
  // Clamp on the upper byte only
  // ---------------------------------------------------------------
  // Fraction bits pass when no limit is hit, cleared when one is
  always_comb begin
    result_o = sample_i;
    if (enable_i) begin
      if (sample_i[LANE_W-1:2] > high_i) begin
        result_o = {high_i, LSB_ZERO};
      end else if (sample_i[LANE_W-1:2] < low_i) begin
        result_o = {low_i, LSB_ZERO};
      end
    end
  end

endmodule : sample_clamp
`default_nettype wire

/* File: src/video_out_stage.sv */
`timescale 1ns/1ps
`default_nettype none
module video_out_stage
  import video_out_pkg::*;
(
  input  wire logic             clock_i,
  input  wire logic             rst_b_i,
  input  wire logic             hsel_i,
  input  wire logic [31:0]      haddr_i,
  input  wire logic [1:0]       htrans_i,
  input  wire logic             hwrite_i,
  input  wire logic [2:0]       hsize_i,
  input  wire logic [31:0]      hwdata_i,
  input  wire logic             hready_i,
  output logic                  hreadyout_o,
  output logic      [31:0]      hrdata_o,
  output logic                  hresp_o,
  input  wire timing_t          timing_i,
  input  wire fifo_word_t       fifo_i,
  output logic      [OUT_W-1:0] video_out_o,
  output logic                  vertical_irq_o
);

  // ---------------------------------------------------------------
  // Bus data phase states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    BUS_IDLE  = 4'b0001,
    BUS_WRITE = 4'b0010,
    BUS_RWAIT = 4'b0100,
    BUS_RDONE = 4'b1000
  } bus_state_t;

  bus_state_t        bus_q,       bus_d;
  logic [ADDR_W-1:0] addr_q,      addr_d;
  logic [31:0]       rdata_q,     rdata_d;
  logic [31:0]       clip_q,      clip_d;
  logic [31:0]       fill_q,      fill_d;
  logic [31:0]       vertical_irq_q,      vertical_irq_d;
  logic [31:0]       ctrl_q,      ctrl_d;
  logic [31:0]       img_off_q,   img_off_d;
  logic [31:0]       img_size_q,  img_size_d;
  logic [OUT_W-1:0]  out_q,       out_d;
  logic              irq_q,       irq_d;
  logic              done_q,      done_d;
  logic              accept;
  logic              raw_mode;
  logic              bt656_mode;
  logic              in_image;
  logic              starve;
  logic              chroma_lo;
  logic              cr_sel;
  logic [LANE_W-1:0] pre_lo,      pre_hi;
  logic [LANE_W-1:0] clip_lo,     clip_hi;
  logic [OUT_W-1:0]  pre_word;
  logic [OUT_W-1:0]  fill_word;
  logic [OUT_W-1:0]  raw_fill;
  logic [31:0]       status;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] byte_at(input logic [31:0] word, input int lsb);
    byte_at = word[lsb +: 8];
  endfunction : byte_at

  function automatic logic [LINE_W-1:0] line_at(input logic [31:0] word, input int lsb);
    line_at = word[lsb +: LINE_W];
  endfunction : line_at

  // Reserved layout follows the mode in force at the access
  function automatic logic [31:0] fill_mask(input logic raw);
    fill_mask = raw ? FILL_RAW_MASK : FILL_YC_MASK;
  endfunction : fill_mask

  // Offset <= count < offset + size, widened to avoid wrap
  function automatic logic in_window(input logic [LINE_W-1:0] cnt,
                                     input logic [LINE_W-1:0] off,
                                     input logic [LINE_W-1:0] size);
    in_window = (cnt >= off) && ({1'b0, cnt} < ({1'b0, off} + {1'b0, size}));
  endfunction : in_window

  // ---------------------------------------------------------------
  // Mode decode and image area
  // ---------------------------------------------------------------
  // Mode code 3 is treated as raw
  assign raw_mode   = ctrl_q[CTRL_MODE_LSB +: 2] > MODE_YC;
  assign bt656_mode = ctrl_q[CTRL_MODE_LSB +: 2] == MODE_BT656;
  assign in_image   = timing_i.active
                    && in_window(timing_i.image_line, line_at(img_off_q, IMG_V_LSB),
                                 line_at(img_size_q, IMG_V_LSB))
                    && in_window(timing_i.image_pixel, line_at(img_off_q, IMG_H_LSB),
                                 line_at(img_size_q, IMG_H_LSB));
  assign starve     = ctrl_q[CTRL_BLANKING_DISABLE] && fifo_i.empty && timing_i.active;
  assign chroma_lo  = bt656_mode && !timing_i.phase[0];
  // BT.656 walks Cb,Y,Cr,Y; Y/C alternates Cb/Cr on phase bit 0
  assign cr_sel     = bt656_mode ? (timing_i.phase == PHASE_CR) : timing_i.phase[0];

  // ---------------------------------------------------------------
  // Fill words
  // ---------------------------------------------------------------
  always_comb begin
    fill_word = '0;
    if (bt656_mode) begin
      if (timing_i.phase == PHASE_CB) begin
        fill_word[LANE_W-1:0] = {byte_at(fill_q, FILL_CB_LSB), LSB_ZERO};
      end else if (timing_i.phase == PHASE_CR) begin
        fill_word[LANE_W-1:0] = {byte_at(fill_q, FILL_CR_LSB), LSB_ZERO};
      end else begin
        fill_word[LANE_W-1:0] = {byte_at(fill_q, FILL_Y_LSB), LSB_ZERO};
      end
    end else begin
      fill_word[LANE_W-1:0] = {byte_at(fill_q, FILL_Y_LSB), LSB_ZERO};
      fill_word[OUT_W-1:LANE_W] = {cr_sel ? byte_at(fill_q, FILL_CR_LSB)
                                          : byte_at(fill_q, FILL_CB_LSB), LSB_ZERO};
    end
  end

  // Raw fill trimmed to the configured bus width
  always_comb begin
    case (ctrl_q[CTRL_WIDTH_LSB +: 2])
      WIDTH_8:  raw_fill = fill_q[OUT_W-1:0] & RAW_MASK_8;
      WIDTH_10: raw_fill = fill_q[OUT_W-1:0] & RAW_MASK_10;
      WIDTH_16: raw_fill = fill_q[OUT_W-1:0] & RAW_MASK_16;
      default:  raw_fill = fill_q[OUT_W-1:0] & RAW_MASK_20;
    endcase
  end

  // ---------------------------------------------------------------
  // Clamp lanes, fed with whatever would otherwise go out
  // ---------------------------------------------------------------
  assign pre_word = starve ? fill_word : fifo_i.data;
  assign pre_lo   = pre_word[LANE_W-1:0];
  assign pre_hi   = pre_word[OUT_W-1:LANE_W];

  sample_clamp u_clamp_lo (
    .sample_i (pre_lo),
    .low_i    (chroma_lo ? byte_at(clip_q, CLIP_CLO_LSB) : byte_at(clip_q, CLIP_YLO_LSB)),
    .high_i   (chroma_lo ? byte_at(clip_q, CLIP_CHI_LSB) : byte_at(clip_q, CLIP_YHI_LSB)),
    .enable_i (!raw_mode && in_image),
    .result_o (clip_lo)
  );

  sample_clamp u_clamp_hi (
    .sample_i (pre_hi),
    .low_i    (byte_at(clip_q, CLIP_CLO_LSB)),
    .high_i   (byte_at(clip_q, CLIP_CHI_LSB)),
    .enable_i (!raw_mode && !bt656_mode && in_image),
    .result_o (clip_hi)
  );

  // ---------------------------------------------------------------
  // Output word selection
  // ---------------------------------------------------------------
  // Clamped value goes straight to the output flop, nothing after it
  always_comb begin
    out_d = fifo_i.data;
    if (raw_mode) begin
      if (!timing_i.active || !in_image || starve) begin
        out_d = raw_fill;
      end
    end else if (timing_i.active && !in_image) begin
      out_d = fill_word;
    end else if (timing_i.active) begin
      out_d = {clip_hi, clip_lo};
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      out_q <= '0;
    end else begin
      out_q <= out_d;
    end
  end

  assign video_out_o = out_q;

  // ---------------------------------------------------------------
  // Vertical line interrupt
  // ---------------------------------------------------------------
  // Edge of line_done so a held strobe still yields one pulse
  always_comb begin
    done_d = timing_i.line_done;
    irq_d  = 1'b0;
    if (timing_i.line_done && !done_q) begin
      if (timing_i.field2) begin
        irq_d = vertical_irq_q[F2_EN_BIT]
             && (timing_i.frame_line == line_at(vertical_irq_q, F2_LINE_LSB));
      end else begin
        irq_d = vertical_irq_q[F1_EN_BIT]
             && (timing_i.frame_line == line_at(vertical_irq_q, F1_LINE_LSB));
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      done_q <= 1'b0;
      irq_q  <= 1'b0;
    end else begin
      done_q <= done_d;
      irq_q  <= irq_d;
    end
  end

  assign vertical_irq_o = irq_q;

  // ---------------------------------------------------------------
  // AHB-Lite slave
  // ---------------------------------------------------------------
  // Reads take one wait state so a write just before is seen
  assign accept      = hsel_i && hready_i && htrans_i[1];
  assign hreadyout_o = (bus_q != BUS_RWAIT);
  assign hresp_o     = 1'b0;
  assign hrdata_o    = rdata_q;
  assign status      = {28'h0, in_image, fifo_i.empty, timing_i.active, timing_i.field2};

  always_comb begin
    bus_d      = BUS_IDLE;
    addr_d     = addr_q;
    rdata_d    = rdata_q;
    clip_d     = clip_q;
    fill_d     = fill_q;
    vertical_irq_d     = vertical_irq_q;
    ctrl_d     = ctrl_q;
    img_off_d  = img_off_q;
    img_size_d = img_size_q;
    if (bus_q == BUS_WRITE) begin
      case (addr_q)
        ADDR_CLIP:     clip_d     = hwdata_i;
        ADDR_FILL:     fill_d     = hwdata_i & fill_mask(raw_mode);
        ADDR_VERTICAL_IRQ:     vertical_irq_d     = hwdata_i & VERTICAL_IRQ_MASK;
        ADDR_CTRL:     ctrl_d     = hwdata_i & CTRL_MASK;
        ADDR_IMG_OFF:  img_off_d  = hwdata_i & IMG_MASK;
        ADDR_IMG_SIZE: img_size_d = hwdata_i & IMG_MASK;
        default:       ;
      endcase
    end
    if (bus_q == BUS_RWAIT) begin
      case (addr_q)
        ADDR_CLIP:     rdata_d = clip_q;
        ADDR_FILL:     rdata_d = fill_q & fill_mask(raw_mode);
        ADDR_VERTICAL_IRQ:     rdata_d = vertical_irq_q;
        ADDR_CTRL:     rdata_d = ctrl_q;
        ADDR_IMG_OFF:  rdata_d = img_off_q;
        ADDR_IMG_SIZE: rdata_d = img_size_q;
        ADDR_STATUS:   rdata_d = status;
        default:       rdata_d = '0;
      endcase
    end
    case (bus_q)
      BUS_RWAIT: bus_d = BUS_RDONE;
      BUS_IDLE, BUS_WRITE, BUS_RDONE: begin
        if (accept) begin
          addr_d = haddr_i[ADDR_W-1:0];
          bus_d  = hwrite_i ? BUS_WRITE : BUS_RWAIT;
        end
      end
      default: bus_d = BUS_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus_q      <= BUS_IDLE;
      addr_q     <= '0;
      rdata_q    <= '0;
      clip_q     <= CLIP_RESET;
      fill_q     <= FILL_RESET;
      vertical_irq_q     <= VERTICAL_IRQ_RESET;
      ctrl_q     <= CTRL_RESET;
      img_off_q  <= IMG_OFF_RESET;
      img_size_q <= IMG_SIZE_RESET;
    end else begin
      bus_q      <= bus_d;
      addr_q     <= addr_d;
      rdata_q    <= rdata_d;
      clip_q     <= clip_d;
      fill_q     <= fill_d;
      vertical_irq_q     <= vertical_irq_d;
      ctrl_q     <= ctrl_d;
      img_off_q  <= img_off_d;
      img_size_q <= img_size_d;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  property p_raw_no_clip; raw_mode && in_image && !starve |=> video_out_o == $past(fifo_i.data); endproperty
  a_raw_no_clip: assert property (p_raw_no_clip) else $error("raw image sample altered");
  property p_luma_high;
    bt656_mode && in_image && !starve && timing_i.phase[0] && fifo_i.data[9:2] > clip_q[15:8]
      |=> video_out_o[9:0] == {$past(clip_q[15:8]), 2'h0};
  endproperty
  a_luma_high: assert property (p_luma_high) else $error("luma not clamped high");
  property p_luma_low;
    bt656_mode && in_image && !starve && timing_i.phase[0] && fifo_i.data[9:2] < clip_q[7:0]
      |=> video_out_o[9:0] == {$past(clip_q[7:0]), 2'h0};
  endproperty
  a_luma_low: assert property (p_luma_low) else $error("luma not clamped low");
  property p_chroma_high;
    !raw_mode && !bt656_mode && in_image && !starve && fifo_i.data[19:12] > clip_q[31:24]
      |=> video_out_o[19:10] == {$past(clip_q[31:24]), 2'h0};
  endproperty
  a_chroma_high: assert property (p_chroma_high) else $error("chroma not clamped high");
  property p_chroma_low;
    bt656_mode && in_image && !starve && !timing_i.phase[0] && fifo_i.data[9:2] < clip_q[23:16]
      |=> video_out_o[9:0] == {$past(clip_q[23:16]), 2'h0};
  endproperty
  a_chroma_low: assert property (p_chroma_low) else $error("chroma not clamped low");
  property p_blank_pass; !raw_mode && !timing_i.active |=> video_out_o == $past(fifo_i.data); endproperty
  a_blank_pass: assert property (p_blank_pass) else $error("blanking sample altered");
  property p_outside_fill;
    bt656_mode && timing_i.active && !in_image && timing_i.phase[0]
      |=> video_out_o == {10'h0, $past(fill_q[7:0]), 2'h0};
  endproperty
  a_outside_fill: assert property (p_outside_fill) else $error("outside image not luma fill");
  property p_raw_blank; raw_mode && !timing_i.active |=> video_out_o == $past(raw_fill); endproperty
  a_raw_blank: assert property (p_raw_blank) else $error("raw blanking not fill");
  property p_starve_yc;
    !raw_mode && !bt656_mode && starve && !in_image |=> video_out_o[9:0] == {$past(fill_q[7:0]), 2'h0};
  endproperty
  a_starve_yc: assert property (p_starve_yc) else $error("starved Y/C not fill");
  property p_irq_pulse; vertical_irq_o |=> !vertical_irq_o; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt longer than one cycle");
  property p_f2_off; timing_i.field2 && !vertical_irq_q[F2_EN_BIT] |=> !vertical_irq_o; endproperty
  a_f2_off: assert property (p_f2_off) else $error("field 2 interrupt while disabled");
  property p_vertical_irq_reserved;
    bus_q == BUS_RDONE && addr_q == ADDR_VERTICAL_IRQ |-> (hrdata_o & ~VERTICAL_IRQ_MASK) == 32'h0;
  endproperty
  a_vertical_irq_reserved: assert property (p_vertical_irq_reserved) else $error("reserved bits read nonzero");

  c_irq:    cover property (vertical_irq_o);
  c_clamp:  cover property (in_image && !raw_mode && clip_lo != pre_lo);
  c_starve: cover property (starve && timing_i.active);
  c_read:   cover property (bus_q == BUS_RWAIT ##1 bus_q == BUS_RDONE);

endmodule : video_out_stage
`default_nettype wire

/* File: sim/video_sink.sv */
`timescale 1ns/1ps
`default_nettype none
// Display side: latches every word the stage drives
module video_sink
  import video_out_pkg::*;
(
  input  wire logic             clock_i,
  input  wire logic [OUT_W-1:0] word_i,
  output logic      [OUT_W-1:0] seen_o
);
  // Same edge a real encoder would use
  always_ff @(posedge clock_i) begin
    seen_o <= word_i;
  end
endmodule : video_sink
`default_nettype wire

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import video_out_pkg::*;
  logic             clock_i, rst_b_i, hsel, hwrite, hready, irq, hresp;
  logic [31:0]      haddr, hwdata, hrdata;
  logic [1:0]       htrans;
  timing_t          tim;
  fifo_word_t       fifo;
  logic [OUT_W-1:0] vout, seen;
  int               errors, cmp_count, cyc;

  video_out_stage uut (.clock_i(clock_i), .rst_b_i(rst_b_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hreadyout_o(hready), .hrdata_o(hrdata), .hresp_o(hresp), .timing_i(tim), .fifo_i(fifo),
    .video_out_o(vout), .vertical_irq_o(irq));
  video_sink sink (.clock_i(clock_i), .word_i(vout), .seen_o(seen));

  // ---------------------------------------------
  // Bus and compare helpers
  // ---------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // Hready and read data taken at the rising edge, before the slave's own update lands
  task automatic rdy(output logic [31:0] d);
    do @(posedge clock_i); while (hready !== 1'b1);
    d = hrdata;
  endtask : rdy
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr  <= {24'h000000, a};
    hwrite <= w;
    rdy(d);
    htrans <= 2'h0;
    hwdata <= wd;
    rdy(d);
  endtask : ahb
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    ahb(1'b1, a, wd, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    ahb(1'b0, a, 32'h00000000, d);
    chk(d, e);
    chk({31'h00000000, hresp}, 32'h00000000);
  endtask : rd
  // One sample in; checked as the display latched it two edges on
  task automatic px(input logic act, input logic [11:0] il, input logic [11:0] ip, input logic [1:0] ph,
                    input logic [19:0] d, input logic emp, input logic [19:0] e);
    tim  <= '{active: act, field2: 1'b0, line_done: 1'b0, frame_line: 12'h000, image_line: il,
              image_pixel: ip, phase: ph};
    fifo <= '{empty: emp, data: d};
    repeat (2) @(posedge clock_i);
    #1 chk({12'h000, seen}, {12'h000, e});
    @(posedge clock_i);
  endtask : px
  // Counts pulse cycles over a window wider than the answer delay
  task automatic ln(input logic f2, input logic [11:0] l, input logic [31:0] e);
    int n;
    n = 0;
    tim <= '{active: 1'b0, field2: f2, line_done: 1'b1, frame_line: l, image_line: 12'h000,
             image_pixel: 12'h000, phase: 2'h0};
    repeat (5) begin
      @(negedge clock_i);
      n = n + ((irq === 1'b1) ? 1 : 0);
    end
    @(posedge clock_i);
    tim.line_done <= 1'b0;
    @(posedge clock_i);
    chk(n, e);
  endtask : ln

  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  task automatic regs_t();
    rd(ADDR_CLIP, 32'hF010EB10);
    wr(ADDR_VERTICAL_IRQ, 32'hFFFFFFFF);
    rd(ADDR_VERTICAL_IRQ, 32'h8FFF8FFF);
    rd(8'h1C, 32'h00000000);
    wr(ADDR_FILL, 32'hFFFFFFFF);
    rd(ADDR_FILL, 32'hFFFF00FF);
  endtask : regs_t
  task automatic clip_t();
    px(1'b1, 12'h0, 12'h0, 2'h1, 20'h003FE, 1'b0, 20'h003AC);
    px(1'b1, 12'h0, 12'h0, 2'h1, 20'h0003D, 1'b0, 20'h00040);
    px(1'b1, 12'h0, 12'h0, 2'h0, 20'hFFFFF, 1'b0, 20'hFFFC0);
    px(1'b1, 12'h0, 12'h0, 2'h2, 20'h00001, 1'b0, 20'h00040);
    px(1'b1, 12'h0, 12'h0, 2'h3, 20'h00201, 1'b0, 20'h00201);
    px(1'b0, 12'h0, 12'h0, 2'h1, 20'h003FF, 1'b0, 20'h003FF);
    wr(ADDR_CTRL, 32'h00000010);
    px(1'b1, 12'h0, 12'h0, 2'h1, 20'h00000, 1'b1, 20'h003AC);
    wr(ADDR_CTRL, 32'h00000001);
    px(1'b1, 12'h0, 12'h0, 2'h0, 20'hFFFFF, 1'b0, 20'hF03AC);
    wr(ADDR_CTRL, 32'h00000002);
    px(1'b1, 12'h0, 12'h0, 2'h1, 20'hFFFFF, 1'b0, 20'hFFFFF);
  endtask : clip_t
  task automatic fill_t();
    wr(ADDR_CTRL, 32'h00000000);
    wr(ADDR_FILL, 32'hAA550033);
    wr(ADDR_IMG_OFF, 32'h00020002);
    px(1'b1, 12'h1, 12'h5, 2'h0, 20'h12345, 1'b0, 20'h00154);
    px(1'b1, 12'h5, 12'h1, 2'h1, 20'h12345, 1'b0, 20'h000CC);
    px(1'b1, 12'h5, 12'h1, 2'h2, 20'h12345, 1'b0, 20'h002A8);
    wr(ADDR_CTRL, 32'h00000001);
    px(1'b1, 12'h1, 12'h5, 2'h0, 20'h12345, 1'b0, 20'h550CC);
    px(1'b1, 12'h1, 12'h5, 2'h1, 20'h12345, 1'b0, 20'hAA0CC);
    wr(ADDR_CTRL, 32'h00000011);
    px(1'b1, 12'h1, 12'h5, 2'h0, 20'h12345, 1'b1, 20'h550CC);
  endtask : fill_t
  // Raw fill is masked at write time, so the mode goes in first
  task automatic raw_t();
    logic [19:0] e [4];
    e = '{20'h000DE, 20'h000DE, 20'h0BCDE, 20'hABCDE};
    wr(ADDR_CTRL, 32'h00000002);
    wr(ADDR_FILL, 32'hFFFABCDE);
    rd(ADDR_FILL, 32'h000ABCDE);
    for (int w = 0; w < 4; w++) begin
      wr(ADDR_CTRL, 32'h00000002 | (w << 2));
      px(1'b0, 12'h0, 12'h0, 2'h0, 20'h12345, 1'b0, e[w]);
    end
    wr(ADDR_CTRL, 32'h0000001E);
    px(1'b1, 12'h5, 12'h5, 2'h0, 20'h12345, 1'b1, 20'hABCDE);
  endtask : raw_t
  task automatic irq_t();
    wr(ADDR_VERTICAL_IRQ, 32'h00078005);
    ln(1'b0, 12'h005, 1);
    ln(1'b0, 12'h004, 0);
    ln(1'b1, 12'h007, 0);
    wr(ADDR_VERTICAL_IRQ, 32'h80070005);
    ln(1'b1, 12'h007, 1);
    ln(1'b0, 12'h005, 0);
  endtask : irq_t

  task automatic results();
    $display("Checks %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // Hang guard, well beyond the roughly 150 cycles the run needs
  initial begin
    cyc = 0;
    forever @(posedge clock_i) begin
      cyc++;
      if (cyc == 20000) begin
        errors++;
        results();
      end
    end
  end
  initial begin
    rst_b_i = 1'b0;
    hsel    = 1'b0;
    htrans  = 2'h0;
    haddr   = 32'h00000000;
    hwrite  = 1'b0;
    hwdata  = 32'h00000000;
    tim     = '0;
    fifo    = '0;
    repeat (2) @(posedge clock_i);
    rst_b_i <= 1'b1;
    @(posedge clock_i);
    regs_t();
    clip_t();
    fill_t();
    raw_t();
    irq_t();
    results();
  end
endmodule : tb_top
`default_nettype wire
